// ==== hw/swe_pkg.sv ====
// Constants and types shared by the single-wire EEPROM read engine
package swe_pkg;

  // Device address opcodes (upper nibble of the device address byte)
  localparam logic [3:0] OP_ZONE = 4'h7;
  localparam logic [3:0] OP_EE   = 4'ha;
  localparam logic [3:0] OP_SEC  = 4'hb;
  localparam logic [3:0] OP_ID   = 4'hc;

  // Array geometry
  localparam int EE_DEPTH       = 128;
  localparam int EE_AW          = 7;
  localparam int SEC_AW         = 5;
  localparam int SEC_USER_DEPTH = 16;
  localparam int NUM_ZONES      = 4;
  localparam int ZONE_LSB       = 5;

  // Security region layout by ptr[4:3]
  localparam logic [1:0] SEC_SN_BLK   = 2'h0;
  localparam logic [1:0] SEC_RSVD_BLK = 2'h1;

  // Protection register addresses, one-hot per zone
  localparam logic [3:0] ZONE0_ADDR = 4'h1;
  localparam logic [3:0] ZONE1_ADDR = 4'h2;
  localparam logic [3:0] ZONE2_ADDR = 4'h4;
  localparam logic [3:0] ZONE3_ADDR = 4'h8;

  // Data values
  localparam logic [7:0] EE_RESET      = 8'hff;
  localparam logic [7:0] SEC_RSVD_VAL  = 8'hff;
  localparam logic [7:0] ZONE_SET_DATA = 8'hff;
  localparam logic [7:0] ZONE_RD_ON    = 8'hff;
  localparam logic [7:0] ZONE_RD_OFF   = 8'h00;
  localparam logic       ZONE_RESET    = 1'b0;

  // Identifier byte index
  localparam logic [1:0] ID_FIRST = 2'h0;
  localparam logic [1:0] ID_LAST  = 2'h2;

  // CRC x^8 + x^5 + x^4 + 1, reflected form, shifted LSB first
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  localparam logic [7:0] CRC_INIT      = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_DEV   = 6'b000010,
    ST_MEM   = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_READ  = 6'b010000,
    ST_SKIP  = 6'b100000
  } swe_state_t;

  typedef enum logic [1:0] {
    TGT_EE   = 2'h0,
    TGT_SEC  = 2'h1,
    TGT_ID   = 2'h2,
    TGT_ZONE = 2'h3
  } swe_tgt_t;

endpackage

// ==== hw/swe_sn_if.sv ====
// Link between the read engine and the serial-number store
`timescale 1ns/1ps
interface swe_sn_if;
  logic [2:0] idx;
  logic [7:0] data;
  modport engine (output idx, input data);
  modport rom    (input idx, output data);
endinterface

// ==== hw/swe_serial_rom.sv ====
// Factory serial number store with its check byte
`timescale 1ns/1ps
module swe_serial_rom #(
  parameter logic [7:0]  PRODUCT_ID = 8'h3c,           // Arbitrary value
  parameter logic [47:0] UNIQUE_NUM = 48'h0123456789ab  // Arbitrary value
) (
  swe_sn_if.rom sn
);

  function automatic logic [7:0] crc56(input logic [55:0] d);
    logic [7:0] c;
    logic       fb;
    c = swe_pkg::CRC_INIT;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ swe_pkg::CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  localparam logic [55:0] SN_BODY = {UNIQUE_NUM, PRODUCT_ID};
  // Byte 0 product id, bytes 1..6 unique number, byte 7 check byte
  localparam logic [63:0] SN_WORD = {crc56(SN_BODY), SN_BODY};

  assign sn.data = SN_WORD[{sn.idx, 3'b000} +: 8];

endmodule // swe_serial_rom

// ==== hw/swe_read_engine.sv ====
// Byte-level command engine: reads, identifier, security region, ROM zones
`timescale 1ns/1ps
module swe_read_engine #(
  parameter logic [2:0]  CLIENT_ADDR = 3'h0,
  parameter logic [11:0] MFR_CODE    = 12'h5a5,          // Arbitrary value
  parameter logic [8:0]  DEV_CODE    = 9'h0a5,           // Arbitrary value
  parameter logic [2:0]  REV_CODE    = 3'h1,             // Arbitrary value
  parameter logic [7:0]  PRODUCT_ID  = 8'h3c,            // Arbitrary value
  parameter logic [47:0] UNIQUE_NUM  = 48'h0123456789ab  // Arbitrary value
) (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       BUS_RESET_IN,
  input  wire logic       START_IN,
  input  wire logic       STOP_IN,
  input  wire logic       BYTE_VALID_IN,
  input  wire logic [7:0] BYTE_IN,
  input  wire logic       HOST_ACK_VALID_IN,
  input  wire logic       HOST_NACK_IN,
  output logic            ACK_VALID_OUT,
  output logic            ACK_OUT,
  output logic            TX_VALID_OUT,
  output logic [7:0]      TX_DATA_OUT,
  output logic [3:0]      ZONE_PROT_OUT
);

  swe_pkg::swe_state_t state_q;
  swe_pkg::swe_state_t state_d;
  swe_pkg::swe_tgt_t   tgt_q;
  swe_pkg::swe_tgt_t   tgt_d;
  swe_pkg::swe_tgt_t   pend_tgt_q;

  logic [6:0] ptr_q;
  logic       ptr_sec_q;
  logic       ptr_sec_d;
  logic       ptr_load;
  logic [1:0] id_idx_q;
  logic       id_rst;
  logic [3:0] zsel_q;
  logic       zsel_load;
  logic       ld_q;
  logic       ld_d;
  logic       ack_ev;
  logic       ack_d;
  logic       wr_ok;
  logic       pend_q;
  logic [7:0] pend_data_q;
  logic       commit;
  logic [7:0] rd_byte;
  logic       ack_valid_q;
  logic       ack_q;
  logic       tx_valid_q;
  logic [7:0] tx_data_q;

  wire  [7:0] ee_cell [swe_pkg::EE_DEPTH];
  wire  [7:0] su_cell [swe_pkg::SEC_USER_DEPTH];
  wire  [3:0] zone_bits;

  logic [3:0] op;
  logic [2:0] ca;
  logic       rd;
  logic       zaddr_ok;
  logic [23:0] id_word;

  assign op       = BYTE_IN[7:4];
  assign ca       = BYTE_IN[3:1];
  assign rd       = BYTE_IN[0];
  assign id_word  = {MFR_CODE, DEV_CODE, REV_CODE};
  // Address low nibble must be exactly one of the four protection register addresses; the upper nibble is ignored
  assign zaddr_ok = (BYTE_IN[3:0] == swe_pkg::ZONE0_ADDR) ||
                    (BYTE_IN[3:0] == swe_pkg::ZONE1_ADDR) ||
                    (BYTE_IN[3:0] == swe_pkg::ZONE2_ADDR) ||
                    (BYTE_IN[3:0] == swe_pkg::ZONE3_ADDR);
  assign commit   = STOP_IN && pend_q && !START_IN && !BUS_RESET_IN;

  swe_sn_if sn ();

  swe_serial_rom #(
    .PRODUCT_ID (PRODUCT_ID),
    .UNIQUE_NUM (UNIQUE_NUM)
  ) u_serial (
    .sn (sn.rom)
  );

  assign sn.idx = ptr_q[2:0];

  // Transaction decode
  always_comb begin
    state_d   = state_q;
    tgt_d     = tgt_q;
    ptr_sec_d = ptr_sec_q;
    ack_ev    = 1'b0;
    ack_d     = 1'b0;
    ld_d      = 1'b0;
    ptr_load  = 1'b0;
    zsel_load = 1'b0;
    id_rst    = 1'b0;
    wr_ok     = 1'b0;
    if (BUS_RESET_IN) begin
      state_d = swe_pkg::ST_IDLE;
    end else if (START_IN) begin
      state_d = swe_pkg::ST_DEV;
    end else if (STOP_IN) begin
      state_d = swe_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        swe_pkg::ST_IDLE, swe_pkg::ST_SKIP: begin
        end
        swe_pkg::ST_DEV: begin
          if (BYTE_VALID_IN) begin
            ack_ev  = 1'b1;
            state_d = swe_pkg::ST_SKIP;
            if (ca == CLIENT_ADDR) begin
              case (op)
                swe_pkg::OP_EE: begin
                  ack_d = 1'b1;
                  tgt_d = swe_pkg::TGT_EE;
                  if (rd) begin
                    state_d = swe_pkg::ST_READ;
                    ld_d    = 1'b1;
                  end else begin
                    state_d = swe_pkg::ST_MEM;
                  end
                end
                swe_pkg::OP_SEC: begin
                  tgt_d = swe_pkg::TGT_SEC;
                  if (!rd) begin
                    ack_d   = 1'b1;
                    state_d = swe_pkg::ST_MEM;
                  end else if (ptr_sec_q) begin
                    // Served only once a dummy write has aimed the pointer here
                    ack_d   = 1'b1;
                    state_d = swe_pkg::ST_READ;
                    ld_d    = 1'b1;
                  end
                end
                swe_pkg::OP_ID: begin
                  if (rd) begin
                    ack_d   = 1'b1;
                    tgt_d   = swe_pkg::TGT_ID;
                    id_rst  = 1'b1;
                    state_d = swe_pkg::ST_READ;
                    ld_d    = 1'b1;
                  end
                end
                swe_pkg::OP_ZONE: begin
                  ack_d = 1'b1;
                  tgt_d = swe_pkg::TGT_ZONE;
                  if (rd) begin
                    state_d = swe_pkg::ST_READ;
                    ld_d    = 1'b1;
                  end else begin
                    state_d = swe_pkg::ST_MEM;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        swe_pkg::ST_MEM: begin
          if (BYTE_VALID_IN) begin
            ack_ev  = 1'b1;
            state_d = swe_pkg::ST_SKIP;
            unique case (tgt_q)
              swe_pkg::TGT_EE: begin
                ptr_load  = 1'b1;
                ptr_sec_d = 1'b0;
                ack_d     = 1'b1;
                state_d   = swe_pkg::ST_WDATA;
              end
              swe_pkg::TGT_SEC: begin
                ptr_load  = 1'b1;
                ptr_sec_d = 1'b1;
                ack_d     = 1'b1;
                state_d   = swe_pkg::ST_WDATA;
              end
              swe_pkg::TGT_ZONE: begin
                zsel_load = 1'b1;
                if (zaddr_ok) begin
                  ack_d   = 1'b1;
                  state_d = swe_pkg::ST_WDATA;
                end
              end
              swe_pkg::TGT_ID: begin
              end
            endcase
          end
        end
        swe_pkg::ST_WDATA: begin
          if (BYTE_VALID_IN) begin
            ack_ev  = 1'b1;
            state_d = swe_pkg::ST_SKIP;
            unique case (tgt_q)
              swe_pkg::TGT_EE: begin
                // Data refused when the addressed zone is read-only
                ack_d = !zone_bits[ptr_q[6:swe_pkg::ZONE_LSB]];
                wr_ok = ack_d;
              end
              swe_pkg::TGT_SEC: begin
                // Serial and reserved bytes are read-only
                ack_d = ptr_q[4];
                wr_ok = ack_d;
              end
              swe_pkg::TGT_ZONE: begin
                ack_d = (BYTE_IN == swe_pkg::ZONE_SET_DATA);
                wr_ok = ack_d;
              end
              swe_pkg::TGT_ID: begin
              end
            endcase
          end
        end
        swe_pkg::ST_READ: begin
          if (HOST_ACK_VALID_IN) begin
            if (HOST_NACK_IN) begin
              state_d = swe_pkg::ST_IDLE;
            end else begin
              ld_d = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Byte presented for the next load
  always_comb begin
    rd_byte = swe_pkg::ZONE_RD_OFF;
    unique case (tgt_q)
      swe_pkg::TGT_EE: begin
        rd_byte = ee_cell[ptr_q];
      end
      swe_pkg::TGT_SEC: begin
        if (ptr_q[4:3] == swe_pkg::SEC_SN_BLK) begin
          rd_byte = sn.data;
        end else if (ptr_q[4:3] == swe_pkg::SEC_RSVD_BLK) begin
          rd_byte = swe_pkg::SEC_RSVD_VAL;
        end else begin
          rd_byte = su_cell[ptr_q[3:0]];
        end
      end
      swe_pkg::TGT_ID: begin
        // Most significant byte first
        unique case (id_idx_q)
          2'h0:    rd_byte = id_word[23:16];
          2'h1:    rd_byte = id_word[15:8];
          default: rd_byte = id_word[7:0];
        endcase
      end
      swe_pkg::TGT_ZONE: begin
        rd_byte = (|(zsel_q & zone_bits)) ? swe_pkg::ZONE_RD_ON
                                          : swe_pkg::ZONE_RD_OFF;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= swe_pkg::ST_IDLE;
      tgt_q   <= swe_pkg::TGT_EE;
    end else begin
      state_q <= state_d;
      tgt_q   <= tgt_d;
    end
  end

  // Shared pointer: survives between operations, cleared only by a reset
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ptr_q     <= '0;
      ptr_sec_q <= 1'b0;
    end else if (BUS_RESET_IN) begin
      ptr_q     <= '0;
      ptr_sec_q <= 1'b0;
    end else if (ptr_load) begin
      ptr_sec_q <= ptr_sec_d;
      if (tgt_q == swe_pkg::TGT_SEC) begin
        ptr_q <= {2'b00, BYTE_IN[swe_pkg::SEC_AW-1:0]};
      end else begin
        ptr_q <= BYTE_IN[swe_pkg::EE_AW-1:0];
      end
    end else if (ld_q && tgt_q == swe_pkg::TGT_EE) begin
      ptr_q <= ptr_q + 7'h01;
    end else if (ld_q && tgt_q == swe_pkg::TGT_SEC) begin
      ptr_q <= {2'b00, ptr_q[4:0] + 5'h01};
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      id_idx_q <= swe_pkg::ID_FIRST;
    end else if (id_rst) begin
      id_idx_q <= swe_pkg::ID_FIRST;
    end else if (ld_q && tgt_q == swe_pkg::TGT_ID) begin
      id_idx_q <= (id_idx_q == swe_pkg::ID_LAST) ? swe_pkg::ID_FIRST
                                                 : id_idx_q + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      zsel_q <= '0;
    end else if (zsel_load) begin
      zsel_q <= BYTE_IN[3:0];
    end
  end

  // Load strobe, then the byte one cycle later
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ld_q       <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
    end else begin
      ld_q       <= ld_d;
      tx_valid_q <= ld_q;
      if (ld_q) begin
        tx_data_q <= rd_byte;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_valid_q <= 1'b0;
      ack_q       <= 1'b0;
    end else begin
      ack_valid_q <= ack_ev;
      if (ack_ev) begin
        ack_q <= ack_d;
      end
    end
  end

  // Writes wait for the stop; a repeated start discards them
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pend_q      <= 1'b0;
      pend_tgt_q  <= swe_pkg::TGT_EE;
      pend_data_q <= '0;
    end else if (START_IN || BUS_RESET_IN) begin
      pend_q <= 1'b0;
    end else if (wr_ok) begin
      pend_q      <= 1'b1;
      pend_tgt_q  <= tgt_q;
      pend_data_q <= BYTE_IN;
    end else if (STOP_IN) begin
      pend_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < swe_pkg::EE_DEPTH; g++) begin : gen_ee
      logic [7:0] cell_q;
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          cell_q <= swe_pkg::EE_RESET;
        end else if (commit && pend_tgt_q == swe_pkg::TGT_EE && ptr_q == 7'(g)) begin
          cell_q <= pend_data_q;
        end
      end
      assign ee_cell[g] = cell_q;
    end
    for (g = 0; g < swe_pkg::SEC_USER_DEPTH; g++) begin : gen_su
      logic [7:0] cell_q;
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          cell_q <= swe_pkg::EE_RESET;
        end else if (commit && pend_tgt_q == swe_pkg::TGT_SEC && ptr_q[3:0] == 4'(g)) begin
          cell_q <= pend_data_q;
        end
      end
      assign su_cell[g] = cell_q;
    end
    // One sticky bit per zone; the bus reset leaves it alone
    for (g = 0; g < swe_pkg::NUM_ZONES; g++) begin : gen_zone
      logic bit_q;
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          bit_q <= swe_pkg::ZONE_RESET;
        end else if (commit && pend_tgt_q == swe_pkg::TGT_ZONE && zsel_q[g]) begin
          bit_q <= 1'b1;
        end
      end
      assign zone_bits[g] = bit_q;
    end
  endgenerate

  assign ACK_VALID_OUT = ack_valid_q;
  assign ACK_OUT       = ack_q;
  assign TX_VALID_OUT  = tx_valid_q;
  assign TX_DATA_OUT   = tx_data_q;
  assign ZONE_PROT_OUT = zone_bits;

endmodule // swe_read_engine

// ==== sim/swe_host.sv ====
// Host model that sequences frames, bytes and acknowledges onto the byte link
`timescale 1ns/1ps
module swe_host (
  input  wire logic       clk_in,
  input  wire logic       ack_valid_in,
  input  wire logic       ack_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            start_out,
  output logic            stop_out,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            hack_valid_out,
  output logic            nack_out
);
  initial begin
    start_out      = 1'b0;
    stop_out       = 1'b0;
    byte_valid_out = 1'b0;
    byte_out       = 8'h00;
    hack_valid_out = 1'b0;
    nack_out       = 1'b0;
  end

  // Every task is entered and left at a falling edge
  task automatic frame(input logic stp);
    stop_out  = stp;
    start_out = !stp;
    @(negedge clk_in);
    stop_out  = 1'b0;
    start_out = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic a);
    byte_valid_out = 1'b1;
    byte_out       = b;
    @(negedge clk_in);
    byte_valid_out = 1'b0;
    // Released byte lines show the inverse so stale data is never read
    byte_out       = ~b;
    for (int i = 0; i < 4 && ack_valid_in !== 1'b1; i++) @(negedge clk_in);
    a = (ack_valid_in === 1'b1) ? ack_in : 1'bx;
  endtask

  task automatic rd_byte(input logic nk, output logic [7:0] d);
    for (int i = 0; i < 6 && tx_valid_in !== 1'b1; i++) @(negedge clk_in);
    d              = (tx_valid_in === 1'b1) ? tx_data_in : 8'hxx;
    hack_valid_out = 1'b1;
    nack_out       = nk;
    @(negedge clk_in);
    hack_valid_out = 1'b0;
    nack_out       = !nk;
  endtask
endmodule // swe_host

// ==== sim/swe_read_engine_assertions.sv ====
// Concurrent checks on the read engine's ports
`timescale 1ns/1ps
module swe_read_engine_assertions (
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic       START_IN,
  input wire logic       STOP_IN,
  input wire logic       BYTE_VALID_IN,
  input wire logic [7:0] BYTE_IN,
  input wire logic       HOST_ACK_VALID_IN,
  input wire logic       HOST_NACK_IN,
  input wire logic       ACK_VALID_OUT,
  input wire logic       ACK_OUT,
  input wire logic       TX_VALID_OUT,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic [3:0] ZONE_PROT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_ack_has_byte: assert property (ACK_VALID_OUT |-> $past(BYTE_VALID_IN))
    else $error("answer without a received byte");
  chk_tx_has_cause: assert property (TX_VALID_OUT |-> $past(BYTE_VALID_IN, 2)
    || ($past(HOST_ACK_VALID_IN, 2) && !$past(HOST_NACK_IN, 2)))
    else $error("byte sent without request or host acknowledge");
  chk_tx_data_held: assert property (!TX_VALID_OUT |-> $stable(TX_DATA_OUT))
    else $error("send data moved without send strobe");
  chk_nack_ends_read: assert property (HOST_ACK_VALID_IN && HOST_NACK_IN
    |=> !TX_VALID_OUT ##1 !TX_VALID_OUT)
    else $error("byte sent after host not-acknowledge");
  chk_id_rw_answer: assert property ($past(START_IN, 2) && $past(BYTE_VALID_IN)
    && (($past(BYTE_IN) & 8'hfe) == 8'hc0)
    |-> ACK_VALID_OUT && (ACK_OUT == ($past(BYTE_IN) == 8'hc1)))
    else $error("identifier opcode answered wrongly");
  chk_zone_sticky: assert property (($past(ZONE_PROT_OUT) & ~ZONE_PROT_OUT) == 4'h0)
    else $error("zone protection bit cleared");
  chk_zone_on_stop: assert property ((ZONE_PROT_OUT != $past(ZONE_PROT_OUT))
    |-> ($past(STOP_IN) || $past(STOP_IN, 2)))
    else $error("zone protection changed without stop");
  chk_zone_one_bit: assert property ((ZONE_PROT_OUT != $past(ZONE_PROT_OUT))
    |-> $onehot(ZONE_PROT_OUT ^ $past(ZONE_PROT_OUT)))
    else $error("more than one zone changed at once");
endmodule // swe_read_engine_assertions

bind swe_read_engine swe_read_engine_assertions i_chk (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .START_IN(START_IN), .STOP_IN(STOP_IN),
  .BYTE_VALID_IN(BYTE_VALID_IN), .BYTE_IN(BYTE_IN), .HOST_ACK_VALID_IN(HOST_ACK_VALID_IN),
  .HOST_NACK_IN(HOST_NACK_IN), .ACK_VALID_OUT(ACK_VALID_OUT), .ACK_OUT(ACK_OUT),
  .TX_VALID_OUT(TX_VALID_OUT), .TX_DATA_OUT(TX_DATA_OUT), .ZONE_PROT_OUT(ZONE_PROT_OUT));

// ==== sim/tb_swe_read_engine.sv ====
// Self-checking bench for the single-wire EEPROM read engine
`timescale 1ns/1ps
module tb_swe_read_engine;
  localparam logic [11:0] MFR = 12'h3a1;          // Arbitrary value
  localparam logic [8:0]  DEV = 9'h0a5;           // Arbitrary value, left at the default
  localparam logic [2:0]  REV = 3'h1;             // Arbitrary value, left at the default
  localparam logic [7:0]  PID = 8'h3c;            // Arbitrary value, left at the default
  localparam logic [47:0] UNQ = 48'h112233445566; // Arbitrary value
  logic       clk = 1'b0;
  logic       rst_n;
  logic       bus_rst;
  logic       start, stop, bv, hv, hn, av, ak, tv;
  logic [7:0] bdat, td;
  logic [3:0] zp;
  int         failures = 0;
  int         samples_checked = 0;

  always #5 clk = ~clk;

  swe_read_engine #(.MFR_CODE(MFR), .UNIQUE_NUM(UNQ)) i_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .BUS_RESET_IN(bus_rst), .START_IN(start),
    .STOP_IN(stop), .BYTE_VALID_IN(bv), .BYTE_IN(bdat), .HOST_ACK_VALID_IN(hv),
    .HOST_NACK_IN(hn), .ACK_VALID_OUT(av), .ACK_OUT(ak), .TX_VALID_OUT(tv),
    .TX_DATA_OUT(td), .ZONE_PROT_OUT(zp));
  swe_host i_host (.clk_in(clk), .ack_valid_in(av), .ack_in(ak), .tx_valid_in(tv),
    .tx_data_in(td), .start_out(start), .stop_out(stop), .byte_valid_out(bv),
    .byte_out(bdat), .hack_valid_out(hv), .nack_out(hn));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic op(input logic [7:0] b, input logic exp, input string what);
    logic a;
    i_host.wr_byte(b, a);
    check(what, {7'h00, a}, {7'h00, exp});
  endtask

  task automatic rd(input logic nk, input logic [7:0] exp, input string what);
    logic [7:0] d;
    i_host.rd_byte(nk, d);
    check(what, d, exp);
  endtask

  task automatic put(input logic [7:0] dv, input logic [7:0] ad, input logic [7:0] da,
                     input logic ok);
    i_host.frame(1'b0);
    op(dv, 1'b1, "write dev ack");
    op(ad, 1'b1, "write addr ack");
    op(da, ok, "write data ack");
    i_host.frame(1'b1);
  endtask

  // Dummy write then repeated start with the read bit set
  task automatic seek(input logic [7:0] dv, input logic [7:0] ad);
    i_host.frame(1'b0);
    op(dv, 1'b1, "dummy dev ack");
    op(ad, 1'b1, "dummy addr ack");
    i_host.frame(1'b0);
    op(dv | 8'h01, 1'b1, "read dev ack");
  endtask

  task automatic bus_reset();
    bus_rst = 1'b1;
    @(negedge clk);
    bus_rst = 1'b0;
  endtask

  function automatic logic [7:0] crc8(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction

  task automatic t_ee();
    put(8'ha0, 8'h7f, 8'h5a, 1'b1);
    put(8'ha0, 8'h00, 8'hc3, 1'b1);
    put(8'ha0, 8'h01, 8'h96, 1'b1);
    seek(8'ha0, 8'h7e);
    rd(1'b0, 8'hff, "ee 7e");
    rd(1'b0, 8'h5a, "ee 7f");
    rd(1'b1, 8'hc3, "ee wrap 00");
    i_host.frame(1'b0);
    op(8'ha1, 1'b1, "current dev ack");
    rd(1'b1, 8'h96, "current read");
    $display("t_ee done");
  endtask

  task automatic t_sec();
    logic [63:0] sn;
    sn = {crc8({UNQ, PID}), UNQ, PID};
    seek(8'hb0, 8'he0);
    for (int k = 0; k <= 32; k++) begin
      rd(k == 32, ((k % 32) < 8) ? sn[8 * (k % 32) +: 8] : 8'hff, "security");
    end
    put(8'hb0, 8'h03, 8'h00, 1'b0);
    put(8'hb0, 8'h12, 8'h77, 1'b1);
    seek(8'hb0, 8'h12);
    rd(1'b1, 8'h77, "security user byte");
    bus_reset();
    i_host.frame(1'b0);
    op(8'hb1, 1'b0, "security current nack");
    i_host.frame(1'b0);
    op(8'ha1, 1'b1, "ee dev ack");
    rd(1'b1, 8'hc3, "pointer after bus reset");
    $display("t_sec done");
  endtask

  task automatic t_id();
    logic [23:0] idv;
    idv = {MFR, DEV, REV};
    i_host.frame(1'b0);
    op(8'hc0, 1'b0, "id write nack");
    i_host.frame(1'b0);
    op(8'hc1, 1'b1, "id read ack");
    for (int k = 0; k < 4; k++) begin
      rd(k == 3, idv[23 - 8 * (k % 3) -: 8], "id byte");
    end
    i_host.frame(1'b0);
    op(8'ha2, 1'b0, "other client nack");
    i_host.frame(1'b0);
    op(8'h50, 1'b0, "unknown opcode nack");
    $display("t_id done");
  endtask

  task automatic t_zone();
    check("zones at reset", {4'h0, zp}, 8'h00);
    seek(8'h70, 8'h04);
    rd(1'b1, 8'h00, "zone2 clear");
    put(8'h70, 8'h04, 8'hff, 1'b1);
    @(negedge clk);
    check("zone2 set", {4'h0, zp}, 8'h04);
    seek(8'h70, 8'h04);
    rd(1'b1, 8'hff, "zone2 read");
    i_host.frame(1'b0);
    op(8'h70, 1'b1, "zone dev ack");
    op(8'h03, 1'b0, "bad zone addr nack");
    put(8'ha0, 8'h40, 8'h11, 1'b0);
    put(8'ha0, 8'h5f, 8'h33, 1'b0);
    put(8'ha0, 8'h3f, 8'h22, 1'b1);
    seek(8'ha0, 8'h3f);
    rd(1'b0, 8'h22, "zone1 written");
    rd(1'b1, 8'hff, "zone2 unchanged");
    bus_reset();
    check("zones after bus reset", {4'h0, zp}, 8'h04);
    $display("t_zone done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end

  initial begin
    rst_n   = 1'b0;
    bus_rst = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_ee();
    t_sec();
    t_id();
    t_zone();
    tally_and_finish();
  end
endmodule // tb_swe_read_engine
